// File: src/csa_alu.sv
// Overview of operation
// RQ1: Compare XORs both operands and writes register 24, sources untouched.
// RQ2: Negate subtracts second operand from zero into the first register.
// RQ3: AND of both operands written to the first register.
// RQ4: OR of both operands written to the first register.
// RQ5: XOR of both operands written to the first register.
// RQ6: Invert complements the second operand into the first register.
// RQ7: Move-in copies any of 32 registers into the short-window destination.
// RQ8: Move-out copies a short-window register into any of 32 registers.
// RQ9: Immediate left shift of word, zero fill, field 0 means eight.
// RQ10: Immediate right zero-fill shift of word, field 0 means eight.
// RQ11: Immediate right sign-fill shift of word, field 0 means eight.
// RQ12: In 64-bit mode every word shift result is sign extended.
// RQ13: Variable left shift by low five count bits into shifted register.
// RQ14: Variable right shift zero fill, low five count bits, into shifted register.
// RQ15: Variable right sign-fill shift by low five count bits.
// RQ16: Doubleword immediate left shift, zero fill, field 0 means eight.
// RQ17: Doubleword immediate right zero-fill shift, field 0 means eight.
// RQ18: Doubleword immediate right sign-fill shift, field 0 means eight.
// RQ19: Doubleword variable shifts use low six count bits.
// RQ20: Doubleword shifts in 32-bit user/supervisor trap, write nothing.
// RQ21: Negate result sign extended in 64-bit mode.
`timescale 1ns/100ps
module csa_alu (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Request from the decoder
    input wire csa_pkg::csa_req_t req_i,
    input wire csa_pkg::csa_mode_t mode_i,
    // Write-back and trap
    output csa_pkg::csa_res_t res_o
);
    typedef struct packed {
        csa_pkg::csa_res_t res;
    } csa_state_t;

    csa_state_t state;
    csa_state_t next_state;

    logic [63:0] sh_value;
    logic [5:0] sh_count;
    csa_pkg::csa_shift_kind_t sh_kind;
    logic sh_wide;
    logic [63:0] sh_result;
    csa_pkg::csa_logic_kind_t lg_kind;
    logic [63:0] lg_result;
    logic is_wide;
    logic wide_allowed;

    csa_shift_unit u_shift (
        .value_i(sh_value),
        .count_i(sh_count),
        .kind_i(sh_kind),
        .wide_i(sh_wide),
        .result_o(sh_result)
    );

    csa_logic_unit u_logic (
        .first_i(req_i.first_val),
        .second_i(req_i.second_val),
        .kind_i(lg_kind),
        .result_o(lg_result)
    );

    // Operand steering for the two units
    always_comb
    begin
        sh_value = req_i.second_val;
        sh_count = csa_pkg::csa_imm_count(req_i.imm); // RQ9 RQ10 RQ11 RQ16 RQ17 RQ18
        sh_kind = csa_pkg::sh_left;
        sh_wide = 1'b0;
        lg_kind = csa_pkg::lg_xor;
        is_wide = 1'b0;
        case (req_i.op)
            csa_pkg::op_zero_minus_operand:
            begin
                lg_kind = csa_pkg::lg_neg;
            end
            csa_pkg::op_and:
            begin
                lg_kind = csa_pkg::lg_and;
            end
            csa_pkg::op_or:
            begin
                lg_kind = csa_pkg::lg_or;
            end
            csa_pkg::op_invert:
            begin
                lg_kind = csa_pkg::lg_not;
            end
            csa_pkg::op_shift_right_zero_immediate:
            begin
                sh_kind = csa_pkg::sh_right_zero;
            end
            csa_pkg::op_shift_right_sign_immediate:
            begin
                sh_kind = csa_pkg::sh_right_sign;
            end
            csa_pkg::op_shift_left_by_register:
            begin
                sh_count = {1'b0, req_i.first_val[csa_pkg::NARROW_CNT_BITS-1:0]}; // RQ13
            end
            csa_pkg::op_shift_right_zero_by_register:
            begin
                sh_kind = csa_pkg::sh_right_zero; // RQ14
                sh_count = {1'b0, req_i.first_val[csa_pkg::NARROW_CNT_BITS-1:0]};
            end
            csa_pkg::op_shift_right_sign_by_register:
            begin
                sh_kind = csa_pkg::sh_right_sign; // RQ15
                sh_count = {1'b0, req_i.first_val[csa_pkg::NARROW_CNT_BITS-1:0]};
            end
            csa_pkg::op_wide_shift_left_immediate:
            begin
                sh_wide = 1'b1; // RQ16
                is_wide = 1'b1;
            end
            csa_pkg::op_wide_shift_right_zero_immediate:
            begin
                sh_kind = csa_pkg::sh_right_zero; // RQ17
                sh_wide = 1'b1;
                is_wide = 1'b1;
            end
            csa_pkg::op_wide_shift_right_sign_immediate:
            begin
                sh_kind = csa_pkg::sh_right_sign; // RQ18
                sh_wide = 1'b1;
                is_wide = 1'b1;
            end
            csa_pkg::op_wide_shift_left_by_register:
            begin
                sh_count = req_i.first_val[csa_pkg::WIDE_CNT_BITS-1:0]; // RQ19
                sh_wide = 1'b1;
                is_wide = 1'b1;
            end
            csa_pkg::op_wide_shift_right_zero_by_register:
            begin
                sh_kind = csa_pkg::sh_right_zero;
                sh_count = req_i.first_val[csa_pkg::WIDE_CNT_BITS-1:0]; // RQ19
                sh_wide = 1'b1;
                is_wide = 1'b1;
            end
            csa_pkg::op_wide_shift_right_sign_by_register:
            begin
                sh_kind = csa_pkg::sh_right_sign;
                sh_count = req_i.first_val[csa_pkg::WIDE_CNT_BITS-1:0]; // RQ19
                sh_wide = 1'b1;
                is_wide = 1'b1;
            end
            default:
            begin
                lg_kind = csa_pkg::lg_xor;
            end
        endcase
        wide_allowed = mode_i.mode64 || mode_i.kernel; // RQ20
    end

    // Destination and data selection
    always_comb
    begin
        next_state = state;
        next_state.res.wr_en = 1'b0;
        next_state.res.resv_exc = 1'b0;
        if (req_i.valid)
        begin
            next_state.res.wr_en = 1'b1;
            next_state.res.wr_idx = req_i.first_idx;
            next_state.res.wr_data = lg_result;
            case (req_i.op)
                csa_pkg::op_equality_test_to_reg24:
                begin
                    next_state.res.wr_idx = csa_pkg::CMP_DEST_IDX; // RQ1
                end
                csa_pkg::op_zero_minus_operand:
                begin
                    next_state.res.wr_data = csa_pkg::csa_fit32(mode_i.mode64, lg_result[31:0]); // RQ2 RQ21
                end
                csa_pkg::op_and, csa_pkg::op_or, csa_pkg::op_xor, csa_pkg::op_invert:
                begin
                    next_state.res.wr_data = lg_result; // RQ3 RQ4 RQ5 RQ6
                end
                csa_pkg::op_move_in:
                begin
                    next_state.res.wr_data = req_i.full_val; // RQ7
                end
                csa_pkg::op_move_out:
                begin
                    next_state.res.wr_idx = req_i.full_idx; // RQ8
                    next_state.res.wr_data = req_i.second_val;
                end
                csa_pkg::op_shift_left_immediate,
                csa_pkg::op_shift_right_zero_immediate,
                csa_pkg::op_shift_right_sign_immediate:
                begin
                    next_state.res.wr_data = csa_pkg::csa_fit32(mode_i.mode64, sh_result[31:0]); // RQ12
                end
                csa_pkg::op_shift_left_by_register,
                csa_pkg::op_shift_right_zero_by_register,
                csa_pkg::op_shift_right_sign_by_register:
                begin
                    next_state.res.wr_idx = req_i.second_idx; // RQ13
                    next_state.res.wr_data = csa_pkg::csa_fit32(mode_i.mode64, sh_result[31:0]); // RQ12
                end
                csa_pkg::op_wide_shift_left_immediate:
                begin
                    next_state.res.wr_data = sh_result;
                end
                default:
                begin
                    next_state.res.wr_idx = req_i.second_idx;
                    next_state.res.wr_data = sh_result;
                end
            endcase
            // A trapped doubleword shift leaves the register file alone
            if (is_wide && !wide_allowed)
            begin
                next_state.res.wr_en = 1'b0; // RQ20
                next_state.res.resv_exc = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state.res.wr_en <= 1'b0;
            state.res.wr_idx <= csa_pkg::IDX_RST;
            state.res.wr_data <= csa_pkg::DATA_RST;
            state.res.resv_exc <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign res_o = state.res;

    chk_cmp_reg24: assert property ( // RQ1
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_equality_test_to_reg24
        |=> res_o.wr_en && res_o.wr_idx == csa_pkg::CMP_DEST_IDX
            && res_o.wr_data == ($past(req_i.first_val) ^ $past(req_i.second_val)))
        else $error("compare result or destination wrong");

    chk_neg_value: assert property ( // RQ2
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_zero_minus_operand
        |=> res_o.wr_en && res_o.wr_idx == $past(req_i.first_idx)
            && res_o.wr_data[31:0] == 32'h0 - $past(req_i.second_val[31:0]))
        else $error("negate result wrong");

    chk_neg_sext: assert property ( // RQ21
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_zero_minus_operand && mode_i.mode64
        |=> res_o.wr_data[63:32] == {32{res_o.wr_data[31]}})
        else $error("negate not sign extended");

    chk_bitwise_ops: assert property ( // RQ3 RQ4 RQ5 RQ6
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op inside {csa_pkg::op_and, csa_pkg::op_or, csa_pkg::op_xor, csa_pkg::op_invert}
        |=> res_o.wr_idx == $past(req_i.first_idx)
            && res_o.wr_data == ($past(req_i.op) == csa_pkg::op_and ? $past(req_i.first_val & req_i.second_val)
                : $past(req_i.op) == csa_pkg::op_or ? $past(req_i.first_val | req_i.second_val)
                : $past(req_i.op) == csa_pkg::op_xor ? $past(req_i.first_val ^ req_i.second_val)
                : ~$past(req_i.second_val)))
        else $error("bitwise result wrong");

    chk_move_paths: assert property ( // RQ8
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_move_out
        |=> res_o.wr_en && res_o.wr_idx == $past(req_i.full_idx) && res_o.wr_data == $past(req_i.second_val))
        else $error("move out wrong");

    chk_imm_zero_eight: assert property ( // RQ9
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_shift_left_immediate && req_i.imm == 3'h0
        |=> res_o.wr_data[31:0] == {$past(req_i.second_val[23:0]), 8'h00})
        else $error("immediate zero not eight");

    chk_word_sext: assert property ( // RQ12
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && mode_i.mode64 && req_i.op inside {csa_pkg::op_shift_left_immediate,
            csa_pkg::op_shift_right_zero_immediate, csa_pkg::op_shift_right_sign_immediate,
            csa_pkg::op_shift_left_by_register, csa_pkg::op_shift_right_zero_by_register,
            csa_pkg::op_shift_right_sign_by_register}
        |=> res_o.wr_data[63:32] == {32{res_o.wr_data[31]}})
        else $error("word shift not sign extended");

    chk_var_zero_fill: assert property ( // RQ14
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_shift_right_zero_by_register
        |=> res_o.wr_idx == $past(req_i.second_idx)
            && res_o.wr_data[31:0] == $past(req_i.second_val[31:0]) >> $past(req_i.first_val[4:0]))
        else $error("variable right shift wrong");

    chk_wide_count: assert property ( // RQ19
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && wide_allowed && req_i.op == csa_pkg::op_wide_shift_left_by_register
        |=> res_o.wr_en && res_o.wr_data == $past(req_i.second_val) << $past(req_i.first_val[5:0]))
        else $error("doubleword variable shift wrong");

    chk_wide_trap: assert property ( // RQ20
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && is_wide && !mode_i.mode64 && !mode_i.kernel
        |=> res_o.resv_exc && !res_o.wr_en ##1 !res_o.resv_exc || $past(req_i.valid))
        else $error("doubleword shift not trapped");

    chk_exc_cause: assert property ( // RQ20
        @(posedge clk_i) disable iff (sys_rst_i)
        res_o.resv_exc |-> $past(req_i.valid) && !$past(wide_allowed) && !res_o.wr_en)
        else $error("trap without cause");

    chk_move_in_copy: assert property ( // RQ7
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_move_in
        |=> res_o.wr_en && res_o.wr_idx == $past(req_i.first_idx) && res_o.wr_data == $past(req_i.full_val))
        else $error("move in wrong");

    chk_imm_right_zero: assert property ( // RQ10
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_shift_right_zero_immediate && req_i.imm == 3'h0
        |=> res_o.wr_data[31:0] == {8'h00, $past(req_i.second_val[31:8])})
        else $error("right zero shift wrong");

    chk_imm_right_sign: assert property ( // RQ11
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_shift_right_sign_immediate && req_i.imm == 3'h0
        |=> res_o.wr_data[31:0] == {{8{$past(req_i.second_val[31])}}, $past(req_i.second_val[31:8])})
        else $error("right sign shift wrong");

    chk_var_left_shift: assert property ( // RQ13
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_shift_left_by_register
        |=> res_o.wr_idx == $past(req_i.second_idx)
            && res_o.wr_data[31:0] == $past(req_i.second_val[31:0]) << $past(req_i.first_val[4:0]))
        else $error("variable left shift wrong");

    chk_var_sign_fill: assert property ( // RQ15
        @(posedge clk_i) disable iff (sys_rst_i)
        req_i.valid && req_i.op == csa_pkg::op_shift_right_sign_by_register
        |=> res_o.wr_data[31:0]
            == $unsigned($signed($past(req_i.second_val[31:0])) >>> $past(req_i.first_val[4:0])))
        else $error("variable sign shift wrong");

endmodule : csa_alu

// File: src/csa_logic_unit.sv
`timescale 1ns/100ps
module csa_logic_unit (
    // Operands
    input wire logic [63:0] first_i,
    input wire logic [63:0] second_i,
    // Operation
    input wire csa_pkg::csa_logic_kind_t kind_i,
    // Result, negate gives a word in the low half
    output logic [63:0] result_o
);
    logic [31:0] diff;

    always_comb
    begin
        diff = 32'h0 - second_i[31:0];
        case (kind_i)
            csa_pkg::lg_xor:
                result_o = first_i ^ second_i;
            csa_pkg::lg_neg:
                result_o = {32'h0, diff};
            csa_pkg::lg_and:
                result_o = first_i & second_i;
            csa_pkg::lg_or:
                result_o = first_i | second_i;
            csa_pkg::lg_not:
                result_o = ~second_i;
            default:
                result_o = 64'h0;
        endcase
    end
endmodule : csa_logic_unit

// File: src/csa_pkg.sv
package csa_pkg;

    // Register index that receives the compare result
    localparam logic [4:0] CMP_DEST_IDX = 5'h18;
    // Immediate shift field value 0 stands for this count
    localparam logic [5:0] IMM_ZERO_COUNT = 6'h08;
    // Count field widths for word and doubleword shifts
    localparam int NARROW_CNT_BITS = 5;
    localparam int WIDE_CNT_BITS = 6;
    // Values after reset
    localparam logic [63:0] DATA_RST = 64'h0000_0000_0000_0000;
    localparam logic [4:0] IDX_RST = 5'h00;

    typedef enum logic [4:0] {
        op_equality_test_to_reg24,
        op_zero_minus_operand,
        op_and,
        op_or,
        op_xor,
        op_invert,
        op_move_in,
        op_move_out,
        op_shift_left_immediate,
        op_shift_right_zero_immediate,
        op_shift_right_sign_immediate,
        op_shift_left_by_register,
        op_shift_right_zero_by_register,
        op_shift_right_sign_by_register,
        op_wide_shift_left_immediate,
        op_wide_shift_right_zero_immediate,
        op_wide_shift_right_sign_immediate,
        op_wide_shift_left_by_register,
        op_wide_shift_right_zero_by_register,
        op_wide_shift_right_sign_by_register
    } csa_op_t;

    typedef enum logic [1:0] {sh_left, sh_right_zero, sh_right_sign} csa_shift_kind_t;

    typedef enum logic [2:0] {lg_xor, lg_neg, lg_and, lg_or, lg_not} csa_logic_kind_t;

    typedef struct packed {
        logic valid;
        csa_op_t op;
        logic [63:0] first_val;
        logic [63:0] second_val;
        logic [63:0] full_val;
        logic [2:0] imm;
        logic [4:0] first_idx;
        logic [4:0] second_idx;
        logic [4:0] full_idx;
    } csa_req_t;

    typedef struct packed {
        logic mode64;
        logic kernel;
    } csa_mode_t;

    typedef struct packed {
        logic wr_en;
        logic [4:0] wr_idx;
        logic [63:0] wr_data;
        logic resv_exc;
    } csa_res_t;

    function automatic logic [5:0] csa_imm_count(input logic [2:0] imm);
        csa_imm_count = (imm == 3'h0) ? IMM_ZERO_COUNT : {3'h0, imm};
    endfunction : csa_imm_count

    // Word result widened as the current mode wants it
    function automatic logic [63:0] csa_fit32(input logic mode64, input logic [31:0] v);
        csa_fit32 = mode64 ? {{32{v[31]}}, v} : {32'h0, v};
    endfunction : csa_fit32

endpackage : csa_pkg

// File: src/csa_shift_unit.sv
`timescale 1ns/100ps
module csa_shift_unit (
    // Operand
    input wire logic [63:0] value_i,
    input wire logic [5:0] count_i,
    // Operation
    input wire csa_pkg::csa_shift_kind_t kind_i,
    input wire logic wide_i,
    // Result, word result in the low half
    output logic [63:0] result_o
);
    logic [31:0] word;
    logic [63:0] dword;
    logic [4:0] wcnt;

    always_comb
    begin
        wcnt = count_i[csa_pkg::NARROW_CNT_BITS-1:0];
        case (kind_i)
            csa_pkg::sh_left:
            begin
                word = value_i[31:0] << wcnt;
                dword = value_i << count_i;
            end
            csa_pkg::sh_right_zero:
            begin
                word = value_i[31:0] >> wcnt;
                dword = value_i >> count_i;
            end
            csa_pkg::sh_right_sign:
            begin
                word = $unsigned($signed(value_i[31:0]) >>> wcnt);
                dword = $unsigned($signed(value_i) >>> count_i);
            end
            default:
            begin
                word = 32'h0;
                dword = 64'h0;
            end
        endcase
        result_o = wide_i ? dword : {32'h0, word};
    end
endmodule : csa_shift_unit

// File: verif/csa_regfile_model.sv
`timescale 1ns/100ps
module csa_regfile_model (
    // Clock
    input wire logic clk_i,
    // Write-back from the datapath
    input wire csa_pkg::csa_res_t res_i,
    // Preload port
    input wire logic load_en_i,
    input wire logic [4:0] load_idx_i,
    input wire logic [63:0] load_val_i,
    // Operand read ports
    input wire logic [4:0] first_idx_i,
    input wire logic [4:0] second_idx_i,
    input wire logic [4:0] full_idx_i,
    output logic [63:0] first_o,
    output logic [63:0] second_o,
    output logic [63:0] full_o
);
    logic [63:0] regs [32];

    initial
    begin
        for (int i = 0; i < 32; i++)
        begin
            regs[i] = 64'h0;
        end
    end

    // A trap pulse leaves the file untouched
    always @(posedge clk_i)
    begin
        if (load_en_i)
        begin
            regs[load_idx_i] <= load_val_i;
        end
        else if (res_i.wr_en)
        begin
            regs[res_i.wr_idx] <= res_i.wr_data;
        end
    end

    assign first_o = regs[first_idx_i];
    assign second_o = regs[second_idx_i];
    assign full_o = regs[full_idx_i];
endmodule : csa_regfile_model

// File: verif/tb_csa_alu.sv
`timescale 1ns/100ps
module tb_csa_alu;
    localparam logic [63:0] VAL_A = 64'h8123_4567_89AB_CDEF;
    localparam logic [63:0] VAL_B = 64'h0F0F_F0F0_3C3C_C3C3;
    logic clk_i;
    logic sys_rst_i;
    logic valid;
    csa_pkg::csa_op_t op;
    logic [2:0] imm;
    logic [4:0] fi;
    logic [4:0] si;
    logic [4:0] xi;
    csa_pkg::csa_mode_t mode;
    csa_pkg::csa_req_t req;
    csa_pkg::csa_res_t res;
    logic load_en;
    logic [4:0] load_idx;
    logic [63:0] load_val;
    logic [63:0] rf_first;
    logic [63:0] rf_second;
    logic [63:0] rf_full;
    int mismatches;
    int checks;

    assign req = {valid, op, rf_first, rf_second, rf_full, imm, fi, si, xi};

    csa_alu i_csa_alu (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .mode_i(mode), .res_o(res));

    csa_regfile_model i_csa_regfile_model (.clk_i(clk_i), .res_i(res), .load_en_i(load_en),
        .load_idx_i(load_idx), .load_val_i(load_val), .first_idx_i(fi), .second_idx_i(si),
        .full_idx_i(xi), .first_o(rf_first), .second_o(rf_second), .full_o(rf_full));

    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        if (mismatches == 0 && checks > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    task automatic put(input logic [4:0] idx, input logic [63:0] val);
        @(negedge clk_i);
        load_en = 1'b1;
        load_idx = idx;
        load_val = val;
        @(negedge clk_i);
        load_en = 1'b0;
    endtask : put

    // One request, result judged just after the next rising edge
    task automatic issue(input csa_pkg::csa_op_t o, input logic [4:0] f, input logic [4:0] s,
        input logic [4:0] x, input logic [2:0] im, input logic m64, input logic kn,
        input logic [4:0] eidx, input logic [63:0] edata, input logic trap);
        @(negedge clk_i);
        valid = 1'b1;
        op = o;
        fi = f;
        si = s;
        xi = x;
        imm = im;
        mode = {m64, kn};
        @(posedge clk_i);
        #1;
        chk("write enable", 64'(res.wr_en), 64'(!trap));
        chk("reserved trap", 64'(res.resv_exc), 64'(trap));
        if (!trap)
        begin
            chk("write index", 64'(res.wr_idx), 64'(eidx));
            chk("write data", res.wr_data, edata);
        end
        @(negedge clk_i);
        valid = 1'b0;
    endtask : issue

    function automatic logic [63:0] exp_shift(input logic [63:0] v, input int k, input int n,
        input logic wide, input logic m64);
        logic [31:0] w;
        logic [63:0] d;
        w = v[31:0] << n;
        d = v << n;
        if (k == 1)
        begin
            w = v[31:0] >> n;
            d = v >> n;
        end
        if (k == 2)
        begin
            w = $signed(v[31:0]) >>> n;
            d = $signed(v) >>> n;
        end
        return wide ? d : (m64 ? {{32{w[31]}}, w} : {32'h0, w});
    endfunction : exp_shift

    task automatic s_reset();
        #1;
        chk("reset state", {57'h0, res.wr_en, res.wr_idx, res.resv_exc}, 64'h0);
        chk("reset data", res.wr_data, 64'h0);
    endtask : s_reset

    task automatic s_logic();
        put(1, VAL_A);
        put(2, VAL_B);
        issue(csa_pkg::op_equality_test_to_reg24, 1, 2, 5'h18, 0, 1, 0, 5'h18, VAL_A ^ VAL_B, 0);
        @(posedge clk_i);
        #1;
        chk("compare target", rf_full, VAL_A ^ VAL_B);
        chk("compare source first", rf_first, VAL_A);
        chk("compare source second", rf_second, VAL_B);
        issue(csa_pkg::op_and, 1, 2, 0, 0, 1, 0, 1, VAL_A & VAL_B, 0);
        put(1, VAL_A);
        issue(csa_pkg::op_or, 1, 2, 0, 0, 0, 0, 1, VAL_A | VAL_B, 0);
        put(1, VAL_A);
        issue(csa_pkg::op_xor, 1, 2, 0, 0, 1, 0, 1, VAL_A ^ VAL_B, 0);
        issue(csa_pkg::op_invert, 1, 2, 0, 0, 1, 0, 1, ~VAL_B, 0);
        issue(csa_pkg::op_zero_minus_operand, 1, 2, 0, 0, 1, 0, 1, 64'hFFFF_FFFF_C3C3_3C3D, 0);
        issue(csa_pkg::op_zero_minus_operand, 1, 2, 0, 0, 0, 0, 1, 64'h0000_0000_C3C3_3C3D, 0);
    endtask : s_logic

    task automatic s_moves();
        put(31, VAL_A);
        issue(csa_pkg::op_move_in, 5, 2, 31, 0, 1, 0, 5, VAL_A, 0);
        issue(csa_pkg::op_move_out, 5, 2, 30, 0, 1, 0, 30, VAL_B, 0);
        @(posedge clk_i);
        #1;
        chk("move in target", rf_first, VAL_A);
        chk("move out target", rf_full, VAL_B);
    endtask : s_moves

    task automatic s_word_imm();
        csa_pkg::csa_op_t ops [3];
        ops = '{csa_pkg::op_shift_left_immediate, csa_pkg::op_shift_right_zero_immediate,
                csa_pkg::op_shift_right_sign_immediate};
        put(1, VAL_A);
        for (int k = 0; k < 3; k++)
        begin
            for (int m = 0; m < 2; m++)
            begin
                for (int i = 0; i < 8; i++)
                begin
                    issue(ops[k], 4, 1, 0, 3'(i), 1'(m), 0, 4, exp_shift(VAL_A, k, (i == 0) ? 8 : i, 0, 1'(m)), 0);
                end
            end
        end
    endtask : s_word_imm

    task automatic s_word_var();
        csa_pkg::csa_op_t ops [3];
        int cs [3];
        ops = '{csa_pkg::op_shift_left_by_register, csa_pkg::op_shift_right_zero_by_register,
                csa_pkg::op_shift_right_sign_by_register};
        cs = '{0, 1, 31};
        for (int k = 0; k < 3; k++)
        begin
            for (int j = 0; j < 6; j++)
            begin
                put(1, VAL_A);
                put(3, 64'hFFFF_FFFF_FFFF_FFE0 | 64'(cs[j % 3]));
                issue(ops[k], 3, 1, 0, 0, 1'(j / 3), 0, 1, exp_shift(VAL_A, k, cs[j % 3], 0, 1'(j / 3)), 0);
            end
        end
    endtask : s_word_var

    task automatic s_wide();
        csa_pkg::csa_op_t ops [6];
        int cs [3];
        ops = '{csa_pkg::op_wide_shift_left_immediate, csa_pkg::op_wide_shift_right_zero_immediate,
                csa_pkg::op_wide_shift_right_sign_immediate, csa_pkg::op_wide_shift_left_by_register,
                csa_pkg::op_wide_shift_right_zero_by_register, csa_pkg::op_wide_shift_right_sign_by_register};
        cs = '{0, 1, 63};
        for (int k = 0; k < 3; k++)
        begin
            for (int i = 0; i < 8; i++)
            begin
                put(1, VAL_A);
                issue(ops[k], 4, 1, 0, 3'(i), 1, 0, (k == 0) ? 5'h04 : 5'h01, exp_shift(VAL_A, k, (i == 0) ? 8 : i, 1, 1), 0);
            end
            for (int j = 0; j < 6; j++)
            begin
                put(1, VAL_A);
                put(3, 64'hFFFF_FFFF_FFFF_FFC0 | 64'(cs[j % 3]));
                issue(ops[k + 3], 3, 1, 0, 0, 1'(j < 3), 1'(j >= 3), 1, exp_shift(VAL_A, k, cs[j % 3], 1, 1), 0);
            end
        end
        put(1, VAL_B);
        put(4, VAL_B);
        for (int k = 0; k < 6; k++)
        begin
            issue(ops[k], 4, 1, 0, 3'h1, 0, 0, 0, 64'h0, 1);
            @(posedge clk_i);
            #1;
            chk("trap pulse length", {62'h0, res.wr_en, res.resv_exc}, 64'h0);
            chk("trap first kept", rf_first, VAL_B);
            chk("trap second kept", rf_second, VAL_B);
        end
    endtask : s_wide

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        sys_rst_i = 1'b1;
        valid = 1'b0;
        op = csa_pkg::op_and;
        imm = 3'h0;
        fi = 5'h00;
        si = 5'h00;
        xi = 5'h00;
        mode = 2'h0;
        load_en = 1'b0;
        load_idx = 5'h00;
        load_val = 64'h0;
        mismatches = 0;
        checks = 0;
        repeat (3) @(posedge clk_i);
        s_reset();
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        s_logic();
        s_moves();
        s_word_imm();
        s_word_var();
        s_wide();
        report_and_stop();
    end
endmodule : tb_csa_alu
